// ==== rtl/brp_pkg.sv ====
package brp_pkg;
   // weighted bcd layout: four full decades plus a two-line top decade
   localparam int DECADES_FULL = 4;
   localparam int DIGIT_W = 4;
   localparam int TOP_W = 2;
   localparam int DATA_W = DECADES_FULL * DIGIT_W + TOP_W;
   localparam int RANGE_W = 4;
   localparam logic [3:0] RANGE_MIN = 4'h0;
   localparam logic [3:0] RANGE_MAX = 4'h7;
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [1:0] TOP_DIGIT_MAX = 2'h2;
   localparam logic [17:0] DATA_RESET = 18'h0_0000;
   localparam logic [3:0] RANGE_RESET = 4'h0;
   localparam logic OVL_RESET = 1'b0;
   localparam logic HOLD_RESET = 1'b0;
   localparam logic [2:0] SYNC_RESET = 3'h0;
   // hold pin synchroniser depth
   localparam int SYNC_STAGES = 3;
endpackage : brp_pkg

// ==== rtl/brp_bcd_port.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - data lines mirror displayed reading as bcd
// - range exponent 0..7, top bit zero
// - overload high marks reading as overload
// - hold input freezes data, range and overload outputs at last values
module brp_bcd_port (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // reading from the measurement core
   input wire logic [17:0] rdg_bcd,
   input wire logic [3:0] rdg_range,
   input wire logic rdg_overload,
   input wire logic rdg_valid,
   // external party
   input wire logic hold_pin,
   output logic [17:0] bcd_data,
   output logic range_exponent_lsb,
   output logic range_exponent_second,
   output logic range_exponent_third,
   output logic range_exponent_msb,
   output logic overload,
   // to measurement core
   output logic meas_halt
);

   logic [2:0] hold_sync_reg;
   logic hold_reg;
   logic [17:0] data_reg;
   logic [3:0] range_reg;
   logic ovl_reg;
   logic take;

   // a digit above nine would be an illegal code on the lines
   function automatic logic bcd_ok(input logic [17:0] v);
      logic ok;
      ok = (v[17:16] <= brp_pkg::TOP_DIGIT_MAX);
      for (int i = 0; i < brp_pkg::DECADES_FULL; i++) begin
         if (v[i*4 +: 4] > brp_pkg::BCD_DIGIT_MAX) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction : bcd_ok

   // exponents past the top range are pinned there so the msb stays zero
   function automatic logic [3:0] clamp_range(input logic [3:0] r);
      logic [3:0] c;
      c = r;
      if (r > brp_pkg::RANGE_MAX) begin
         c = brp_pkg::RANGE_MAX;
      end
      return c;
   endfunction : clamp_range

   // three stages; the change counts when stages two and three agree
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hold_sync_reg <= brp_pkg::SYNC_RESET;
      end else begin
         hold_sync_reg <= {hold_sync_reg[1:0], hold_pin};
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hold_reg <= brp_pkg::HOLD_RESET;
      end else if (hold_sync_reg[1] == hold_sync_reg[2]) begin
         hold_reg <= hold_sync_reg[2];
      end
   end

   assign meas_halt = hold_reg;
   assign take = rdg_valid && !hold_reg;

   // one register for the whole reading so no digit mix is seen
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         data_reg <= brp_pkg::DATA_RESET;
         range_reg <= brp_pkg::RANGE_RESET;
         ovl_reg <= brp_pkg::OVL_RESET;
      end else if (take) begin
         data_reg <= rdg_bcd;
         // out-of-range exponent clamps to the top range
         range_reg <= clamp_range(rdg_range);
         // illegal digits are reported as overload, data then meaningless
         ovl_reg <= rdg_overload || !bcd_ok(rdg_bcd);
      end
   end

   assign bcd_data = data_reg;
   assign range_exponent_lsb = range_reg[0];
   assign range_exponent_second = range_reg[1];
   assign range_exponent_third = range_reg[2];
   assign range_exponent_msb = range_reg[3];
   assign overload = ovl_reg;

   // five edges cover three stages plus the agreement check on the hold pin
   sequence s_pin_high_run;
      hold_pin [*5];
   endsequence : s_pin_high_run

   sequence s_pin_low_run;
      !hold_pin [*5];
   endsequence : s_pin_low_run

   // one sampled pulse between quiet windows must never reach the core
   sequence s_pin_glitch;
      s_pin_low_run ##1 hold_pin ##1 s_pin_low_run;
   endsequence : s_pin_glitch

   // a reading taken, and one with legal digits and no overload
   sequence s_take;
      take;
   endsequence : s_take

   sequence s_take_clean;
      take && !rdg_overload && bcd_ok(rdg_bcd);
   endsequence : s_take_clean

   // first reading once the hold has just been let go
   sequence s_resume;
      $fell(hold_reg) && take;
   endsequence : s_resume

   // nothing moves on the lines while the hold stands
   property p_hold_freeze;
      @(posedge core_clk) disable iff (!rstn)
      $past(hold_reg) |-> $stable(data_reg) && $stable(range_reg) && $stable(ovl_reg);
   endproperty : p_hold_freeze
   a_hold_freeze: assert property (p_hold_freeze) else $error("change in hold");

   // top exponent bit unused, only eight ranges exist
   property p_msb_zero;
      @(posedge core_clk) disable iff (!rstn)
      range_exponent_msb == 1'b0;
   endproperty : p_msb_zero
   a_msb_zero: assert property (p_msb_zero) else $error("range msb not zero");

   // data lines carry the reading one cycle after it is taken
   property p_data_load;
      @(posedge core_clk) disable iff (!rstn)
      s_take |=> bcd_data == $past(rdg_bcd);
   endproperty : p_data_load
   a_data_load: assert property (p_data_load) else $error("data not loaded");

   // overload readings raise the flag
   property p_ovl_set;
      @(posedge core_clk) disable iff (!rstn)
      take && rdg_overload |=> overload;
   endproperty : p_ovl_set
   a_ovl_set: assert property (p_ovl_set) else $error("overload missed");

   // an illegal digit code is shown as overload
   property p_bad_digit;
      @(posedge core_clk) disable iff (!rstn)
      take && !bcd_ok(rdg_bcd) |=> overload;
   endproperty : p_bad_digit
   a_bad_digit: assert property (p_bad_digit) else $error("bad digit passed");

   // a clean reading drops the flag again
   property p_ovl_clear;
      @(posedge core_clk) disable iff (!rstn)
      s_take_clean |=> !overload;
   endproperty : p_ovl_clear
   a_ovl_clear: assert property (p_ovl_clear) else $error("false overload");

   // legal exponents pass unchanged
   property p_range_load;
      @(posedge core_clk) disable iff (!rstn)
      take && rdg_range <= brp_pkg::RANGE_MAX |=> range_reg == $past(rdg_range);
   endproperty : p_range_load
   a_range_load: assert property (p_range_load) else $error("range not loaded");

   // exponents past the top range show the top range
   property p_range_clamp;
      @(posedge core_clk) disable iff (!rstn)
      take && rdg_range > brp_pkg::RANGE_MAX |=> range_reg == brp_pkg::RANGE_MAX;
   endproperty : p_range_clamp
   a_range_clamp: assert property (p_range_clamp) else $error("range not clamped");

   // a steady high pin halts measurement
   property p_hold_sync;
      @(posedge core_clk) disable iff (!rstn)
      s_pin_high_run |-> hold_reg;
   endproperty : p_hold_sync
   a_hold_sync: assert property (p_hold_sync) else $error("hold not taken");

   // a steady low pin lets measurement run
   property p_hold_release;
      @(posedge core_clk) disable iff (!rstn)
      s_pin_low_run |-> !hold_reg;
   endproperty : p_hold_release
   a_hold_release: assert property (p_hold_release) else $error("hold stuck");

   // costs one cycle of latency but keeps pin noise from halting the core
   property p_hold_glitch;
      @(posedge core_clk) disable iff (!rstn)
      s_pin_glitch |-> !hold_reg;
   endproperty : p_hold_glitch
   a_hold_glitch: assert property (p_hold_glitch) else $error("glitch taken");

   // readings flow again as soon as the hold ends
   property p_hold_resume;
      @(posedge core_clk) disable iff (!rstn)
      s_resume |=> bcd_data == $past(rdg_bcd);
   endproperty : p_hold_resume
   a_hold_resume: assert property (p_hold_resume) else $error("no resume");

   // data and flag only move with a taken reading
   property p_lines_together;
      @(posedge core_clk) disable iff (!rstn)
      !$past(take) |-> $stable(bcd_data) && $stable(overload);
   endproperty : p_lines_together
   a_lines_together: assert property (p_lines_together) else $error("lone change");

   // range lines move with the same reading as the data
   property p_range_steady;
      @(posedge core_clk) disable iff (!rstn)
      !$past(take) |-> $stable(range_reg);
   endproperty : p_range_steady
   a_range_steady: assert property (p_range_steady) else $error("range moved");
endmodule : brp_bcd_port

// ==== bench/brp_logger.sv ====
`timescale 1ns/1ps
module brp_logger (
   // sampled lines
   input wire logic core_clk,
   input wire logic [17:0] bcd_data,
   input wire logic overload,
   input wire logic hold_req,
   // run/hold line
   output logic hold_pin,
   output logic [17:0] last_rdg
);
   assign hold_pin = hold_req;
   // data ignored while overload, it is arbitrary then
   always_ff @(posedge core_clk) begin
      if (!overload) begin
         last_rdg <= bcd_data;
      end
   end
endmodule : brp_logger

// ==== bench/brp_bcd_port_bench.sv ====
`timescale 1ns/1ps
module brp_bcd_port_bench;
   logic core_clk, rstn, rdg_overload, rdg_valid, hold_req, hold_pin, overload, meas_halt, e_ovl;
   logic e_halt;
   logic [17:0] rdg_bcd, bcd_data, e_data, last_rdg, e_log;
   logic [3:0] rdg_range, rng, e_rng, hh;
   int error_cnt, checks_done, seed;
   brp_bcd_port dut_u (.core_clk(core_clk), .rstn(rstn), .rdg_bcd(rdg_bcd),
      .rdg_range(rdg_range), .rdg_overload(rdg_overload), .rdg_valid(rdg_valid),
      .hold_pin(hold_pin), .bcd_data(bcd_data), .range_exponent_lsb(rng[0]),
      .range_exponent_second(rng[1]), .range_exponent_third(rng[2]),
      .range_exponent_msb(rng[3]), .overload(overload), .meas_halt(meas_halt));
   brp_logger log_u (.core_clk(core_clk), .bcd_data(bcd_data), .overload(overload),
      .hold_req(hold_req), .hold_pin(hold_pin), .last_rdg(last_rdg));
   task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      {rstn, rdg_overload, rdg_valid, hold_req, rdg_bcd, rdg_range} = '0;
      {e_data, e_rng, e_ovl, e_halt, e_log, hh} = '0;
      seed = 32'h7f50_6f35;
      error_cnt = 0;
      checks_done = 0;
      repeat (3) @(negedge core_clk);
      rstn = 1;
      for (int c = 0; c < 400; c++) begin
         @(negedge core_clk);
         // a hold change counts once the second and third stage agree
         if (hh[2] == hh[3]) begin
            e_halt = hh[3];
         end
         chk("halt", 18'(meas_halt), 18'(e_halt));
         chk("overload", 18'(overload), 18'(e_ovl));
         chk("range", 18'(rng), 18'(e_rng));
         chk("logged", last_rdg, e_log);
         if (!e_ovl) begin
            chk("data", bcd_data, e_data);
         end
         // mid-run reset clears every line at once
         if (c == 300) begin
            rstn = 0;
            {e_data, e_rng, e_ovl, e_halt, hh} = '0;
         end
         if (c == 302) begin
            rstn = 1;
         end
         if (!e_ovl) begin
            e_log = e_data;
         end
         // long hold, a one-cycle glitch to be filtered, a two-cycle pulse
         hold_req = (c >= 100 && c < 160) || c == 200 || c == 230 || c == 231;
         hh = {hh[2:0], hold_req};
         rdg_valid = $random(seed) % 3 != 0;
         rdg_overload = $random(seed) % 8 == 0;
         // extra code values reach clamp and bad-digit paths
         rdg_range = 4'($unsigned($random(seed)) % 9);
         for (int i = 0; i < 4; i++) rdg_bcd[4*i+:4] = 4'($unsigned($random(seed)) % 11);
         rdg_bcd[17:16] = 2'($unsigned($random(seed)) % 4);
         if (rdg_valid && !e_halt && rstn) begin
            e_data = rdg_bcd;
            e_rng = rdg_range > 4'h7 ? 4'h7 : rdg_range;
            e_ovl = rdg_overload || rdg_bcd[17:16] > 2'h2;
            for (int i = 0; i < 4; i++) e_ovl |= rdg_bcd[4*i+:4] > 4'h9;
         end
      end
      wrap_up();
   end
endmodule : brp_bcd_port_bench
